//--- scmc_clk_gate.v
`timescale 1ns/100ps
`default_nettype none
// Enable-based glitch-free switch between two clock enable sources.
module scmc_clk_gate (
   // Clock and reset
   input  wire       clk,
   input  wire       resetn,
   // Source request
   input  wire       want_fast,
   input  wire       fast_en,
   input  wire       slow_en,
   // Selected source
   output reg        fast_sel_ff,
   output wire       sys_en
);
   reg             nxt_fast_sel;

   // Switch only when both sources are between pulses, so no partial pulse passes.
   always @* begin
      nxt_fast_sel = fast_sel_ff;
      if (want_fast != fast_sel_ff && !fast_en && !slow_en) begin
         nxt_fast_sel = want_fast;
      end
   end

   always @(posedge clk) begin
      if (!resetn) begin
         fast_sel_ff <= 1'b1;
      end else begin
         fast_sel_ff <= nxt_fast_sel;
      end
   end

   assign sys_en = fast_sel_ff ? fast_en : slow_en;
endmodule // scmc_clk_gate
`default_nettype wire

//--- scmc_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module scmc_core_model (
   // Clock and bench command
   input  wire logic clk,
   input  wire logic halt_go,
   // Oscillator enables
   input  wire logic fast_osc_enable,
   input  wire logic slow_osc_enable,
   // Toward the controller
   output var logic  halt_req,
   output var logic  fast_tick,
   output var logic  slow_tick
);
   logic [2:0] phase_ff;
   logic       go_ff;
   initial {phase_ff, go_ff, halt_req, fast_tick, slow_tick} = '0;
   // Fast ticks every second cycle, slow every eighth; a disabled oscillator stands still.
   always @(posedge clk) begin
      phase_ff <= phase_ff + 3'h1;
      fast_tick <= fast_osc_enable & phase_ff[0];
      slow_tick <= slow_osc_enable & (phase_ff == 3'h0);
      go_ff <= halt_go;
      halt_req <= halt_go & ~go_ff;
   end
endmodule // scmc_core_model
`default_nettype wire

//--- scmc_ctrl.v
`timescale 1ns/100ps
`default_nettype none
`include "scmc_map.vh"
module scmc_ctrl (
   // Clock and reset
   input  wire       clk,
   input  wire       resetn,
   // Avalon-MM slave
   input  wire [3:0] avs_address,
   input  wire       avs_read,
   input  wire       avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0] avs_byteenable,
   output wire [31:0] avs_readdata,
   output wire       avs_waitrequest,
   output wire [1:0] avs_response,
   // Oscillator ticks, one-cycle enables from the analog wrappers
   input  wire       fast_tick,
   input  wire       slow_tick,
   // CPU core
   input  wire       halt_req,
   input  wire       wake_evt,
   output wire       cpu_run,
   // Other reset and enable sources
   input  wire       brownout_evt,
   input  wire       threshold_bad,
   input  wire       watchdog_cfg_evt,
   input  wire       watchdog_enable,
   input  wire       low_volt_detect_enable,
   // Clock, bandgap and soft reset outputs
   output wire       fast_osc_enable,
   output wire       slow_osc_enable,
   output wire       system_clock_en,
   output wire       timebase_clock_en,
   output wire       aux_slow_clock_en,
   output wire       bandgap_keep,
   output wire       soft_reset_req
);
   localparam [4:0] ST_RUN   = 5'h01;
   localparam [4:0] ST_SLEEP = 5'h02;
   localparam [4:0] ST_IDLE_CLOCK_STOPPED = 5'h04;
   localparam [4:0] ST_IDLE_CLOCK_RUNNING = 5'h08;
   localparam [4:0] ST_WAKE  = 5'h10;

   // Registers.
   reg [7:0]       mode_ff;
   reg [7:0]       rstf_ff;
   reg [4:0]       state_ff;
   reg [4:0]       nxt_state;
   reg [15:0]      fcnt_ff;
   reg [15:0]      scnt_ff;
   reg             frdy_ff;
   reg             srdy_ff;
   reg [5:0]       div_ff;
   reg             div_en_ff;
   reg             ack_ff;
   reg [31:0]      rdata_ff;
   reg             err_ff;
   reg [2:0]       sync_a_ff;
   reg [2:0]       sync_b_ff;
   reg             thbad_d_ff;

   wire            hcs      = mode_ff[`SCMC_MODE_HCS];
   wire            idle_on  = mode_ff[`SCMC_MODE_IDLE];
   wire [2:0]      div_sel  = mode_ff[`SCMC_MODE_DIV_HI:`SCMC_MODE_DIV_LO];
   wire            keep_sys = rstf_ff[`SCMC_RSTF_KEEP];
   wire            bo_s     = sync_b_ff[0];
   wire            th_s     = sync_b_ff[1];
   wire            wd_s     = sync_b_ff[2];
   wire            access   = avs_read | avs_write;

   // Returns the fast divider mask: output pulses when counter bits are all ones.
   function [5:0] div_mask;
      input [2:0] sel;
      begin
         case (sel)
            3'h2:    div_mask = 6'h3F;
            3'h3:    div_mask = 6'h1F;
            3'h4:    div_mask = 6'h0F;
            3'h5:    div_mask = 6'h07;
            3'h6:    div_mask = 6'h03;
            3'h7:    div_mask = 6'h01;
            default: div_mask = 6'h00;
         endcase
      end
   endfunction

   // Source choice.
   wire use_fast = hcs | (div_sel > `SCMC_DIV_SLOW1);
   wire fast_sel;
   wire sel_en;

   // Fast oscillator runs only when chosen, and not in sleep or clock-stopped idle.
   assign fast_osc_enable = use_fast &
                            ((state_ff == ST_RUN) | (state_ff == ST_IDLE_CLOCK_RUNNING) |
                             (state_ff == ST_WAKE));
   // Slow oscillator stays on in every mode except sleep without a user.
   assign slow_osc_enable = (state_ff != ST_SLEEP) | low_volt_detect_enable |
                            watchdog_enable;

   wire fast_live = fast_tick & fast_osc_enable;
   wire slow_live = slow_tick & slow_osc_enable;

   // Divided fast clock.
   always @(posedge clk) begin
      if (!resetn) begin
         div_ff    <= 6'h00;
         div_en_ff <= 1'b0;
      end else begin
         div_en_ff <= 1'b0;
         if (fast_live) begin
            div_ff    <= div_ff + 6'h01;
            div_en_ff <= ((div_ff & div_mask(div_sel)) == div_mask(div_sel));
         end
      end
   end

   wire fast_src_en = hcs ? fast_live : div_en_ff;

   scmc_clk_gate u_gate (
      .clk         (clk),
      .resetn      (resetn),
      .want_fast   (use_fast),
      .fast_en     (fast_src_en),
      .slow_en     (slow_live),
      .fast_sel_ff (fast_sel),
      .sys_en      (sel_en)
   );

   // CPU and peripheral clock gating per mode.
   wire sys_on = (state_ff == ST_RUN) | (state_ff == ST_IDLE_CLOCK_RUNNING);
   assign system_clock_en   = sel_en & sys_on;
   assign cpu_run           = (state_ff == ST_RUN);
   assign timebase_clock_en = slow_live & (state_ff != ST_SLEEP);
   assign aux_slow_clock_en = slow_live;
   assign bandgap_keep      = low_volt_detect_enable;
   assign soft_reset_req    = th_s;

   // Power mode machine.
   always @* begin
      case (state_ff)
         ST_RUN: begin
            if (halt_req) begin
               if (!idle_on) begin
                  nxt_state = ST_SLEEP;
               end else if (keep_sys) begin
                  nxt_state = ST_IDLE_CLOCK_RUNNING;
               end else begin
                  nxt_state = ST_IDLE_CLOCK_STOPPED;
               end
            end else begin
               nxt_state = ST_RUN;
            end
         end
         ST_SLEEP, ST_IDLE_CLOCK_STOPPED, ST_IDLE_CLOCK_RUNNING: begin
            nxt_state = wake_evt ? ST_WAKE : state_ff;
         end
         ST_WAKE: begin
            // Resume once the required oscillator has settled.
            nxt_state = (use_fast ? frdy_ff : srdy_ff) ? ST_RUN : ST_WAKE;
         end
         default: nxt_state = ST_RUN;
      endcase
   end

   // Settle counters and ready flags.
   always @(posedge clk) begin
      if (!resetn) begin
         state_ff <= ST_RUN;
         fcnt_ff  <= 16'h0000;
         scnt_ff  <= 16'h0000;
         frdy_ff  <= 1'b0;
         srdy_ff  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         if (!fast_osc_enable) begin
            fcnt_ff <= 16'h0000;
            frdy_ff <= 1'b0;
         end else if (fast_tick && !frdy_ff) begin
            if (fcnt_ff == `SCMC_SETTLE_CYC - 16'h0001) begin
               frdy_ff <= 1'b1;
            end
            fcnt_ff <= fcnt_ff + 16'h0001;
         end
         if (!slow_osc_enable) begin
            scnt_ff <= 16'h0000;
            srdy_ff <= 1'b0;
         end else if (slow_tick && !srdy_ff) begin
            if (scnt_ff == `SCMC_SETTLE_CYC - 16'h0001) begin
               srdy_ff <= 1'b1;
            end
            scnt_ff <= scnt_ff + 16'h0001;
         end
      end
   end

   // Event inputs from other logic sources are synchronised.
   always @(posedge clk) begin
      if (!resetn) begin
         sync_a_ff  <= 3'h0;
         sync_b_ff  <= 3'h0;
         thbad_d_ff <= 1'b0;
      end else begin
         sync_a_ff  <= {watchdog_cfg_evt, threshold_bad, brownout_evt};
         sync_b_ff  <= sync_a_ff;
         thbad_d_ff <= th_s;
      end
   end

   // Bus access: one wait cycle, then answer with waitrequest low.
   wire sel_mode = (avs_address == `SCMC_ADDR_MODE);
   wire sel_rstf = (avs_address == `SCMC_ADDR_RSTF);
   wire sel_stat = (avs_address == `SCMC_ADDR_STAT);
   wire take     = access & ack_ff;
   wire wr_mode  = take & avs_write & sel_mode & avs_byteenable[0];
   wire wr_rstf  = take & avs_write & sel_rstf & avs_byteenable[0];
   wire [7:0] wd = avs_writedata[7:0];

   always @(posedge clk) begin
      if (!resetn) begin
         mode_ff <= `SCMC_MODE_RESET;
         rstf_ff <= `SCMC_RSTF_RESET;
      end else begin
         if (wr_mode) begin
            mode_ff <= (wd & `SCMC_MODE_WMASK) | (mode_ff & ~`SCMC_MODE_WMASK);
         end
         if (wr_rstf) begin
            rstf_ff[`SCMC_RSTF_KEEP] <= wd[`SCMC_RSTF_KEEP];
         end
         // Flags clear only on a written zero, and a new event wins over the clear.
         rstf_ff[`SCMC_RSTF_BOR] <= bo_s |
            (rstf_ff[`SCMC_RSTF_BOR] & ~(wr_rstf & ~wd[`SCMC_RSTF_BOR]));
         rstf_ff[`SCMC_RSTF_BADTH] <= (th_s & ~thbad_d_ff) |
            (rstf_ff[`SCMC_RSTF_BADTH] & ~(wr_rstf & ~wd[`SCMC_RSTF_BADTH]));
         rstf_ff[`SCMC_RSTF_WDG] <= wd_s |
            (rstf_ff[`SCMC_RSTF_WDG] & ~(wr_rstf & ~wd[`SCMC_RSTF_WDG]));
         rstf_ff[6:3] <= 4'h0;
      end
   end

   always @(posedge clk) begin
      if (!resetn) begin
         ack_ff   <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         err_ff   <= 1'b0;
      end else begin
         ack_ff <= access & ~ack_ff;
         if (access & ~ack_ff) begin
            err_ff <= ~(sel_mode | sel_rstf | sel_stat);
            if (sel_mode) begin
               // Ready flags come from hardware; bit 4 reads as zero.
               rdata_ff <= {24'h000000, mode_ff[7:5], 1'b0, srdy_ff, frdy_ff,
                            mode_ff[1:0]};
            end else if (sel_rstf) begin
               rdata_ff <= {24'h000000, rstf_ff[7], 4'h0, rstf_ff[2:0]};
            end else if (sel_stat) begin
               rdata_ff <= {26'h0000000, fast_sel, state_ff};
            end else begin
               rdata_ff <= 32'h0000_0000;
            end
         end
      end
   end

   assign avs_waitrequest = access & ~ack_ff;
   assign avs_readdata    = rdata_ff;
   assign avs_response    = err_ff ? 2'h2 : 2'h0;
endmodule // scmc_ctrl
`default_nettype wire

//--- scmc_ctrl_checker.sv
`timescale 1ns/100ps
`default_nettype none
module scmc_chk (
   // Clock and reset
   input wire logic        clk,
   input wire logic        resetn,
   // Register bus
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic [1:0]  avs_response,
   // Core and reset sources
   input wire logic        halt_req,
   input wire logic        cpu_run,
   input wire logic        threshold_bad,
   input wire logic        soft_reset_req,
   input wire logic        low_volt_detect_enable,
   input wire logic        bandgap_keep
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   wire req = avs_read | avs_write;
   wire hit = avs_address inside {4'h0, 4'h4, 4'h8};
   sequence s_new; !req ##1 req; endsequence
   sequence s_done; req && !avs_waitrequest; endsequence
   AST_WAIT_ONE: assert property (s_new |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus answer not one cycle after request");
   AST_RESP_ERR: assert property (s_done |-> hit || avs_response == 2'h2)
      else $error("unmapped access not refused");
   AST_RESP_OK: assert property (s_done |-> !hit || avs_response == 2'h0)
      else $error("mapped access refused");
   AST_READ_ZERO: assert property (s_done |-> !avs_read || avs_readdata[31:8] == 24'h0)
      else $error("unused read bits not zero");
   AST_HALT_STOP: assert property (cpu_run && halt_req |=> !cpu_run [*2])
      else $error("core kept running after halt");
   AST_BANDGAP: assert property (bandgap_keep == low_volt_detect_enable)
      else $error("bandgap hold does not follow detect enable");
   AST_SOFT_SET: assert property (threshold_bad [*3] |-> soft_reset_req)
      else $error("bad threshold gave no soft reset");
   AST_SOFT_CLR: assert property (!threshold_bad [*3] |-> !soft_reset_req)
      else $error("soft reset without bad threshold");
endmodule // scmc_chk
bind scmc_ctrl scmc_chk u_chk (.clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_readdata,
   .avs_waitrequest, .avs_response, .halt_req, .cpu_run, .threshold_bad, .soft_reset_req,
   .low_volt_detect_enable, .bandgap_keep);
`default_nettype wire

//--- scmc_map.vh
`ifndef SCMC_MAP_VH
`define SCMC_MAP_VH
// Register byte addresses (word aligned).
`define SCMC_ADDR_MODE        4'h0
`define SCMC_ADDR_RSTF        4'h4
`define SCMC_ADDR_STAT        4'h8
// Clock mode register fields.
`define SCMC_MODE_HCS         0
`define SCMC_MODE_IDLE        1
`define SCMC_MODE_FRDY        2
`define SCMC_MODE_SRDY        3
`define SCMC_MODE_DIV_LO      5
`define SCMC_MODE_DIV_HI      7
`define SCMC_MODE_RESET       8'hC2
`define SCMC_MODE_WMASK       8'hE3
// Reset cause register fields.
`define SCMC_RSTF_WDG         0
`define SCMC_RSTF_BADTH       1
`define SCMC_RSTF_BOR         2
`define SCMC_RSTF_KEEP        7
`define SCMC_RSTF_RESET       8'h00
// Divider select codes.
`define SCMC_DIV_SLOW1        3'h1
// Oscillator settle time, counted in cycles of the oscillator.
`define SCMC_SETTLE_CYC       16'h0400
`endif

//--- system_clock_mode_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
module system_clock_mode_control_bench;
   logic        clk, resetn, avs_read, avs_write, halt_go, wake_evt, halt_req, cpu_run;
   logic        brownout_evt, threshold_bad, watchdog_cfg_evt, low_volt_detect_enable;
   logic        fast_tick, slow_tick, fast_osc_enable, slow_osc_enable, system_clock_en;
   logic        timebase_clock_en, aux_slow_clock_en, bandgap_keep, soft_reset_req;
   logic        avs_waitrequest;
   logic [3:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, lfsr, rd;
   logic [1:0]  avs_response, rsp;
   logic [7:0]  mode_m, flag_m;
   int          err_count, comparisons, n, sys_n, tb_n, aux_n;
   scmc_ctrl u_dut (.clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .avs_response, .fast_tick,
      .slow_tick, .halt_req, .wake_evt, .cpu_run, .brownout_evt, .threshold_bad,
      .watchdog_cfg_evt, .watchdog_enable(1'b0), .low_volt_detect_enable, .fast_osc_enable,
      .slow_osc_enable, .system_clock_en, .timebase_clock_en, .aux_slow_clock_en,
      .bandgap_keep, .soft_reset_req);
   scmc_core_model u_core (.clk, .halt_go, .fast_osc_enable, .slow_osc_enable, .halt_req,
      .fast_tick, .slow_tick);
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic close_out;
      $display("errors %0d, comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic fail(input logic [31:0] got, input logic [31:0] exp);
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
   endtask
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) fail(got, exp);
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) fail(got, exp);
   endtask
   task automatic chk_cnt(input int got, input int exp);
      comparisons++;
      if (got < exp - 1 || got > exp + 1) fail(got, exp);
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_read <= ~wr;
      avs_write <= wr;
      n = 0;
      @(negedge clk);
      while (avs_waitrequest !== 1'b0 && n < 50) begin
         n++;
         @(negedge clk);
      end
      if (n == 50) fail(n, 1);
      rd = avs_readdata;
      rsp = avs_response;
      @(posedge clk);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic count(input int cyc);
      @(negedge clk);
      {sys_n, tb_n, aux_n} = '0;
      repeat (cyc) @(negedge clk);
   endtask
   always @(posedge clk) begin
      sys_n += system_clock_en;
      tb_n += timebase_clock_en;
      aux_n += aux_slow_clock_en;
   end
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      repeat (60000) @(posedge clk);
      err_count++;
      close_out;
   end
   initial begin
      {avs_read, avs_write, halt_go, wake_evt, brownout_evt, threshold_bad} = '0;
      {watchdog_cfg_evt, low_volt_detect_enable, resetn, avs_address, avs_writedata} = '0;
      {err_count, comparisons} = '0;
      lfsr = 32'h0000FE37;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      bus(0, 4'h0, 8'h00);
      chk_reg(rd[7:0], 8'hC2);
      bus(0, 4'h4, 8'h00);
      chk_reg(rd[7:0], 8'h00);
      bus(1, 4'hC, 8'hFF);
      chk_reg({6'h0, rsp}, 8'h02);
      bus(0, 4'hC, 8'h00);
      chk_reg(rd[7:0], 8'h00);
      for (int i = 0; i < 6; i++) begin
         lfsr = lfsr_next(lfsr);
         mode_m = lfsr[7:0] & 8'hE3;
         bus(1, 4'h0, lfsr[7:0]);
         bus(0, 4'h0, 8'h00);
         chk_reg(rd[7:0] & 8'hF3, mode_m);
      end
      {brownout_evt, threshold_bad, watchdog_cfg_evt} <= 3'h7;
      repeat (4) @(posedge clk);
      {brownout_evt, threshold_bad, watchdog_cfg_evt} <= 3'h0;
      repeat (4) @(posedge clk);
      flag_m = 8'h07;
      foreach (flag_m[i]) if (i == 0) bus(0, 4'h4, 8'h00);
      chk_reg(rd[7:0], flag_m);
      bus(1, 4'h4, 8'h83);
      flag_m = 8'h83;
      bus(0, 4'h4, 8'h00);
      chk_reg(rd[7:0], flag_m);
      bus(1, 4'h4, 8'h00);
      bus(0, 4'h4, 8'h00);
      chk_reg(rd[7:0], 8'h00);
      for (int c = 0; c < 9; c++) begin
         mode_m = (c < 8) ? 8'(c << 5) : 8'h01;
         bus(1, 4'h0, mode_m);
         repeat (2200) @(posedge clk);
         if (c < 2) bus(0, 4'h0, 8'h00);
         if (c < 2) chk_bit(rd[2] | fast_osc_enable, 1'b0);
         count(512);
         chk_cnt(sys_n, c == 8 ? 256 : c < 2 ? 64 : 256 >> (8 - c));
      end
      n = 0;
      do bus(0, 4'h0, 8'h00); while (rd[2] !== 1'b1 && n++ < 1000);
      chk_bit(rd[2], 1'b1);
      chk_bit(rd[3], 1'b1);
      low_volt_detect_enable <= 1'b1;
      for (int k = 0; k < 3; k++) begin
         bus(1, 4'h0, k > 0 ? 8'hC2 : 8'hC0);
         bus(1, 4'h4, k == 2 ? 8'h80 : 8'h00);
         halt_go <= 1'b1;
         repeat (2) @(posedge clk);
         halt_go <= 1'b0;
         repeat (4) @(posedge clk);
         bus(0, 4'h8, 8'h00);
         chk_reg({3'h0, rd[4:0]}, 8'h02 << k);
         count(512);
         chk_bit(sys_n > 0, k == 2);
         chk_bit(tb_n > 0, k > 0);
         chk_bit(aux_n > 0, 1'b1);
         chk_bit(fast_osc_enable, k == 2);
         wake_evt <= 1'b1;
         @(posedge clk);
         wake_evt <= 1'b0;
         n = 0;
         while (cpu_run !== 1'b1 && n++ < 20000) @(negedge clk);
         chk_bit(cpu_run, 1'b1);
      end
      close_out;
   end
endmodule // system_clock_mode_control_bench
`default_nettype wire
